// ===== verilog/fbh_histogram.sv
// Frame brightness histogram unit: binning, saved copy, threshold events, APB registers.
// Assumes the pixel stream and vblank pulse come from logic on clk; APB on clk too.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module fbh_histogram
   import fbh_pkg::*;
#(
   parameter int BIN_W = BIN_CNT_W
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Pixel stream
   input  wire logic         pixValid,
   input  wire fbh_pix_t     pixData,
   input  wire logic         vblankStart,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Threshold interrupt
   output logic              histIrq
);

   function automatic logic isMapped(input logic [11:0] a);
      return (a == CTRL_OFFS) || (a == GUARD_OFFS) || (a == BIN_OFFS);
   endfunction

   // Control state
   logic                 enShadow_ff, nxt_enShadow;
   logic                 enLive_ff, nxt_enLive;
   fbh_mode_t            mode_ff, nxt_mode;
   fbh_func_t            funcShadow_ff, nxt_funcShadow;
   fbh_func_t            funcLive_ff, nxt_funcLive;
   logic [BIN_IDX_W-1:0] idx_ff, nxt_idx;
   logic [GUARD_W-1:0]   guard_ff, nxt_guard;
   logic [DELAY_W-1:0]   delay_ff, nxt_delay;
   logic                 intEn_ff, nxt_intEn;
   logic                 status_ff, nxt_status;
   logic                 busy_ff, nxt_busy;
   logic [DELAY_W-1:0]   frameCnt_ff, nxt_frameCnt;
   logic [31:0]          rdData_ff, nxt_rdData;

   // Histogram storage
   logic [BIN_W-1:0]     curBins_ff [NUM_BINS];
   logic [BIN_W-1:0]     nxt_curBins [NUM_BINS];
   logic [BIN_W-1:0]     savBins_ff [NUM_BINS];
   logic [BIN_W-1:0]     nxt_savBins [NUM_BINS];

   logic                 binValid;
   logic [BIN_IDX_W-1:0] binNum;
   logic                 setupRd, wrDone, rdDone;
   logic                 wrCtrl, wrGuard, rdBin;
   logic                 frameEnd, exceed, event_w;
   logic [BIN_W-1:0]     diff;
   logic [DELAY_W:0]     cntNext;

   fbh_brightness u_bright (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .inValid  (pixValid & enLive_ff),
      .inPix    (pixData),
      .mode     (mode_ff),
      .outValid (binValid),
      .outBin   (binNum)
   );

   // APB decode; zero wait states
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~isMapped(paddr);
   assign prdata  = rdData_ff;
   assign histIrq = status_ff & intEn_ff;

   always_comb begin
      setupRd  = ce & psel & ~penable & ~pwrite;
      wrDone   = ce & psel & penable & pwrite;
      rdDone   = ce & psel & penable & ~pwrite;
      wrCtrl   = wrDone & (paddr == CTRL_OFFS);
      wrGuard  = wrDone & (paddr == GUARD_OFFS);
      rdBin    = rdDone & (paddr == BIN_OFFS);
      frameEnd = ce & vblankStart;
      // Compare every current bin against its saved copy
      exceed = 1'b0;
      diff   = '0;
      for (int i = 0; i < NUM_BINS; i++) begin
         diff = (curBins_ff[i] >= savBins_ff[i]) ? curBins_ff[i] - savBins_ff[i]
                                                 : savBins_ff[i] - curBins_ff[i];
         if (diff > BIN_W'(guard_ff)) begin
            exceed = 1'b1;
         end
      end
      cntNext = (DELAY_W+1)'(frameCnt_ff) + (DELAY_W+1)'(1);
      // A set status holds off new events until software clears it
      event_w = frameEnd & enLive_ff & exceed & ~status_ff &
                (cntNext >= (DELAY_W+1)'(delay_ff));
   end

   // Register file and frame control
   always_comb begin
      nxt_enShadow   = enShadow_ff;
      nxt_enLive     = enLive_ff;
      nxt_mode       = mode_ff;
      nxt_funcShadow = funcShadow_ff;
      nxt_funcLive   = funcLive_ff;
      nxt_idx        = idx_ff;
      nxt_guard      = guard_ff;
      nxt_delay      = delay_ff;
      nxt_intEn      = intEn_ff;
      nxt_status     = status_ff;
      nxt_busy       = busy_ff;
      nxt_frameCnt   = frameCnt_ff;
      nxt_rdData     = rdData_ff;
      if (wrCtrl) begin
         nxt_enShadow   = pwdata[CTRL_EN_BIT];
         nxt_mode       = fbh_mode_t'(pwdata[CTRL_MODE_BIT]);
         nxt_funcShadow = fbh_func_t'(pwdata[CTRL_FUNC_BIT]);
         nxt_idx        = pwdata[CTRL_IDX_LSB +: BIN_IDX_W];
         nxt_busy       = 1'b0;
      end
      if (rdBin) begin
         nxt_idx = idx_ff + BIN_IDX_W'(1);
      end
      if (wrGuard) begin
         nxt_guard = pwdata[GRD_BAND_LSB +: GUARD_W];
         nxt_delay = pwdata[GRD_DLY_LSB +: DELAY_W];
         nxt_intEn = pwdata[GRD_IE_BIT];
         if (pwdata[GRD_STAT_BIT]) begin
            nxt_status = 1'b0;
         end
      end
      if (frameEnd) begin
         // Shadow values go live only at the start of vertical blank
         nxt_enLive   = enShadow_ff;
         nxt_funcLive = funcShadow_ff;
         if (!enLive_ff || !exceed) begin
            nxt_frameCnt = '0;
         end else if (event_w) begin
            nxt_frameCnt = '0;
         end else if (!status_ff) begin
            nxt_frameCnt = cntNext[DELAY_W-1:0];
         end
      end
      // Hardware set wins over a clear in the same cycle
      if (event_w) begin
         nxt_status = 1'b1;
         nxt_busy   = 1'b1;
      end
      if (setupRd) begin
         nxt_rdData = '0;
         unique case (paddr)
            CTRL_OFFS: begin
               nxt_rdData[CTRL_EN_BIT]                  = enShadow_ff;
               nxt_rdData[CTRL_MODE_BIT]                = mode_ff;
               nxt_rdData[CTRL_FUNC_BIT]                = funcShadow_ff;
               nxt_rdData[CTRL_IDX_LSB +: BIN_IDX_W]    = idx_ff;
               nxt_rdData[CTRL_LIVE_BIT]                = enLive_ff;
            end
            GUARD_OFFS: begin
               nxt_rdData[GRD_BAND_LSB +: GUARD_W]      = guard_ff;
               nxt_rdData[GRD_DLY_LSB +: DELAY_W]       = delay_ff;
               nxt_rdData[GRD_IE_BIT]                   = intEn_ff;
               nxt_rdData[GRD_STAT_BIT]                 = status_ff;
            end
            BIN_OFFS: begin
               nxt_rdData[BIN_W-1:0]   = savBins_ff[idx_ff];
               // Saved copy changed or wrong function live: data is not trustworthy
               nxt_rdData[BIN_BUSY_BIT] = busy_ff | event_w |
                                          (funcLive_ff != FBH_FUNC_COUNT);
            end
            default: nxt_rdData = '0;
         endcase
      end
   end

   // Histogram accumulation and save
   always_comb begin
      for (int i = 0; i < NUM_BINS; i++) begin
         nxt_curBins[i] = curBins_ff[i];
         nxt_savBins[i] = savBins_ff[i];
         if (event_w) begin
            nxt_savBins[i] = curBins_ff[i];
         end
         if (frameEnd) begin
            nxt_curBins[i] = '0;
         end else if (ce && binValid && binNum == BIN_IDX_W'(i) && !(&curBins_ff[i])) begin
            nxt_curBins[i] = curBins_ff[i] + BIN_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enShadow_ff   <= 1'b0;
         enLive_ff     <= 1'b0;
         mode_ff       <= FBH_MODE_MAX;
         funcShadow_ff <= FBH_FUNC_COUNT;
         funcLive_ff   <= FBH_FUNC_COUNT;
         idx_ff        <= '0;
         guard_ff      <= '0;
         delay_ff      <= '0;
         intEn_ff      <= 1'b0;
         status_ff     <= 1'b0;
         busy_ff       <= 1'b0;
         frameCnt_ff   <= '0;
         rdData_ff     <= '0;
         for (int i = 0; i < NUM_BINS; i++) begin
            curBins_ff[i] <= '0;
            savBins_ff[i] <= '0;
         end
      end else if (ce) begin
         enShadow_ff   <= nxt_enShadow;
         enLive_ff     <= nxt_enLive;
         mode_ff       <= nxt_mode;
         funcShadow_ff <= nxt_funcShadow;
         funcLive_ff   <= nxt_funcLive;
         idx_ff        <= nxt_idx;
         guard_ff      <= nxt_guard;
         delay_ff      <= nxt_delay;
         intEn_ff      <= nxt_intEn;
         status_ff     <= nxt_status;
         busy_ff       <= nxt_busy;
         frameCnt_ff   <= nxt_frameCnt;
         rdData_ff     <= nxt_rdData;
         for (int i = 0; i < NUM_BINS; i++) begin
            curBins_ff[i] <= nxt_curBins[i];
            savBins_ff[i] <= nxt_savBins[i];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_enWrite;
      wrCtrl && pwdata[CTRL_EN_BIT] && !enLive_ff && !frameEnd;
   endsequence

   property p_enDeferred;
      s_enWrite ##1 (!frameEnd && ce) [*2] |-> !enLive_ff;
   endproperty
   a_enDeferred: assert property (p_enDeferred)
      else $error("Histogram enable took effect before vertical blank");

   property p_enAtVblank;
      frameEnd |=> enLive_ff == $past(enShadow_ff);
   endproperty
   a_enAtVblank: assert property (p_enAtVblank)
      else $error("Histogram enable not loaded at vertical blank");

   property p_idxAdvance;
      rdBin && !wrCtrl |=> idx_ff == $past(idx_ff) + BIN_IDX_W'(1);
   endproperty
   a_idxAdvance: assert property (p_idxAdvance)
      else $error("Bin index did not advance after bin read");

   property p_saveCopy;
      event_w |=> savBins_ff[0] == $past(curBins_ff[0]) && savBins_ff[NUM_BINS-1] == $past(curBins_ff[NUM_BINS-1]);
   endproperty
   a_saveCopy: assert property (p_saveCopy)
      else $error("Saved histogram not copied on threshold event");

   property p_noSaveWithoutEvent;
      ce && !event_w |=> savBins_ff[0] == $past(savBins_ff[0]);
   endproperty
   a_noSaveWithoutEvent: assert property (p_noSaveWithoutEvent)
      else $error("Saved histogram changed without event");

   property p_statusSet;
      event_w |=> status_ff && busy_ff && frameCnt_ff == '0;
   endproperty
   a_statusSet: assert property (p_statusSet)
      else $error("Event did not set status, busy and clear counter");

   property p_w1c;
      wrGuard && pwdata[GRD_STAT_BIT] && !event_w |=> !status_ff;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Status not cleared by write of one");

   property p_w0keeps;
      wrGuard && !pwdata[GRD_STAT_BIT] && status_ff |=> status_ff;
   endproperty
   a_w0keeps: assert property (p_w0keeps)
      else $error("Status cleared by write of zero");

   property p_irqGate;
      (event_w && intEn_ff && !wrGuard |=> histIrq) and (!intEn_ff |-> !histIrq);
   endproperty
   a_irqGate: assert property (p_irqGate)
      else $error("Interrupt missing after enabled event or raised while disabled");

   property p_cntReset;
      frameEnd && !exceed |=> frameCnt_ff == '0;
   endproperty
   a_cntReset: assert property (p_cntReset)
      else $error("Frame counter not reset on quiet frame");

   property p_noEarlyEvent;
      frameEnd && (DELAY_W+1)'(frameCnt_ff) + (DELAY_W+1)'(1) < (DELAY_W+1)'(delay_ff) |-> !event_w;
   endproperty
   a_noEarlyEvent: assert property (p_noEarlyEvent)
      else $error("Threshold event before consecutive frame count");

   property p_curClear;
      frameEnd |=> curBins_ff[0] == '0;
   endproperty
   a_curClear: assert property (p_curClear)
      else $error("Current histogram not restarted at frame end");

endmodule // fbh_histogram

// ===== verilog/fbh_pkg.sv
// Constants, register map and types for the frame brightness histogram unit.
// Assumes one pixel clock for pixel stream, vertical blank timing and APB.
// What this block does
// - Build a brightness histogram every frame; mode picks max of RGB or luma.
// - Thirty-two bins, eight values each; the lowest bin counts zero to seven.
// - Wider components use only their top eight bits.
// - Bin counters never overflow for the largest supported image.
// - Histogram enable is double buffered, taking effect at the next vertical blank.
// - Keep current and saved histograms; copy current to saved after a threshold event.
// - Each bin-port read advances the index; software reads all 32 bins.
// - Bin port returns busy; on busy software discards data and restarts at zero.
// - Any bin differing from saved by more than guardband flags exceedance at vblank.
// - Threshold event only after the programmed number of consecutive exceeding frames.
// - Threshold interrupt is signalled only while the interrupt enable is set.
// - Sticky status is set with the event; it must be cleared for further events.
package fbh_pkg;

   localparam int          NUM_BINS      = 32;
   localparam int          BIN_IDX_W     = 5;
   localparam int          HIST_BITS     = 8;
   localparam int          COMP_W        = 10;
   localparam int          BIN_CNT_W     = 27;
   localparam int          GUARD_W       = 22;
   localparam int          DELAY_W       = 8;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFFS     = 12'h000;
   localparam logic [11:0] GUARD_OFFS    = 12'h004;
   localparam logic [11:0] BIN_OFFS      = 12'h008;

   // Control register fields
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_MODE_BIT = 1;
   localparam int          CTRL_FUNC_BIT = 2;
   localparam int          CTRL_IDX_LSB  = 8;
   localparam int          CTRL_LIVE_BIT = 16;

   // Guard register fields
   localparam int          GRD_BAND_LSB  = 0;
   localparam int          GRD_DLY_LSB   = 22;
   localparam int          GRD_IE_BIT    = 30;
   localparam int          GRD_STAT_BIT  = 31;

   // Bin port fields
   localparam int          BIN_BUSY_BIT  = 31;

   // Luma weights, summing to 256 so the result stays within eight bits
   localparam logic [7:0]  LUMA_R        = 8'h4D;
   localparam logic [7:0]  LUMA_G        = 8'h96;
   localparam logic [7:0]  LUMA_B        = 8'h1D;

   typedef enum logic {
      FBH_MODE_MAX  = 1'b0,
      FBH_MODE_LUMA = 1'b1
   } fbh_mode_t;

   typedef enum logic {
      FBH_FUNC_COUNT   = 1'b0,
      FBH_FUNC_ENHANCE = 1'b1
   } fbh_func_t;

   typedef struct packed {
      logic [COMP_W-1:0] red;
      logic [COMP_W-1:0] green;
      logic [COMP_W-1:0] blue;
   } fbh_pix_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fbh_apb_req_t;

endpackage

// ===== verilog/fbh_brightness.sv
// Brightness stage: turns one pixel into a histogram bin number.
// Assumes pixels arrive on the same clock, at most one per cycle.
`timescale 1ns/10ps
module fbh_brightness
   import fbh_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // Pixel in
   input  wire logic                 inValid,
   input  wire fbh_pix_t             inPix,
   input  wire fbh_mode_t            mode,
   // Bin out
   output logic                      outValid,
   output logic [BIN_IDX_W-1:0]      outBin
);

   logic [HIST_BITS-1:0] r8;
   logic [HIST_BITS-1:0] g8;
   logic [HIST_BITS-1:0] b8;
   logic [HIST_BITS-1:0] maxVal;
   logic [17:0]          lumaSum;
   logic [HIST_BITS-1:0] bright;
   logic                 nxt_outValid;
   logic [BIN_IDX_W-1:0] nxt_outBin;
   logic                 outValid_ff;
   logic [BIN_IDX_W-1:0] outBin_ff;

   always_comb begin
      r8      = inPix.red[COMP_W-1 -: HIST_BITS];
      g8      = inPix.green[COMP_W-1 -: HIST_BITS];
      b8      = inPix.blue[COMP_W-1 -: HIST_BITS];
      maxVal  = (r8 > g8) ? r8 : g8;
      maxVal  = (b8 > maxVal) ? b8 : maxVal;
      lumaSum = 18'(r8) * 18'(LUMA_R) + 18'(g8) * 18'(LUMA_G) + 18'(b8) * 18'(LUMA_B);
      bright  = (mode == FBH_MODE_LUMA) ? lumaSum[15:8] : maxVal;
      nxt_outValid = ce ? inValid : outValid_ff;
      nxt_outBin   = ce ? bright[HIST_BITS-1 -: BIN_IDX_W] : outBin_ff;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outValid_ff <= 1'b0;
         outBin_ff   <= '0;
      end else begin
         outValid_ff <= nxt_outValid;
         outBin_ff   <= nxt_outBin;
      end
   end

   assign outValid = outValid_ff;
   assign outBin   = outBin_ff;

endmodule // fbh_brightness

// ===== dv/fbh_pix_source.sv
// Stand-in for the display pipe: pixel stream and vertical blank pulses.
// Assumes the bench calls sendFrame; outputs change only right after a rising edge.
`timescale 1ns/10ps
module fbh_pix_source
   import fbh_pkg::*;
(
   // Clock
   input  wire logic clk,
   // Stream out
   output logic      pixValid,
   output fbh_pix_t  pixData,
   output logic      vblankStart
);
   initial begin
      pixValid    = 1'b0;
      pixData     = '0;
      vblankStart = 1'b0;
   end

   // Idle data toggles so a stale pixel is never mistaken for a held one
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         pixValid    <= 1'b0;
         vblankStart <= 1'b0;
         pixData     <= ~pixData;
      end
   endtask

   // Slow mode leaves a bubble after every pixel
   task automatic sendFrame(input fbh_pix_t pix, input int n, input logic slow);
      repeat (n) begin
         @(posedge clk);
         pixValid <= 1'b1;
         pixData  <= pix;
         if (slow) idle(1);
      end
      // Idle gap lets the binning pipe drain before the frame closes
      idle(3);
      @(posedge clk);
      pixValid    <= 1'b0;
      pixData     <= ~pix;
      vblankStart <= 1'b1;
      idle(3);
   endtask
endmodule // fbh_pix_source

// ===== dv/fbh_tb.sv
// Self-checking bench for the histogram unit: APB master, table of pixel rows, edge cases.
// Assumes fbh_pix_source drives the pixel side; one 100 MHz clock for everything.
`timescale 1ns/10ps
module tb
   import fbh_pkg::*;
;
   typedef struct {
      fbh_pix_t  pix;
      fbh_mode_t mode;
      int        bin;
   } fbh_row_t;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd, ctl;
   logic        pready, pslverr, histIrq, pixValid, vblankStart, err;
   fbh_pix_t    pixData;
   int          errorCnt = 0;
   int          totalChecks = 0;
   fbh_row_t    rows [8] = '{
      '{'{10'h3FF, 10'h000, 10'h000}, FBH_MODE_MAX, 31},
      '{'{10'h01F, 10'h01C, 10'h000}, FBH_MODE_MAX, 0},
      '{'{10'h020, 10'h000, 10'h000}, FBH_MODE_MAX, 1},
      '{'{10'h000, 10'h2A7, 10'h003}, FBH_MODE_MAX, 21},
      '{'{10'h3FF, 10'h3FF, 10'h3FF}, FBH_MODE_LUMA, 31},
      '{'{10'h200, 10'h100, 10'h080}, FBH_MODE_LUMA, 9},
      '{'{10'h000, 10'h000, 10'h3FF}, FBH_MODE_LUMA, 3},
      '{'{10'h000, 10'h000, 10'h1FF}, FBH_MODE_MAX, 15}};

   always #5 clk = ~clk;

   fbh_histogram #(.BIN_W(BIN_CNT_W)) DUT (
      .clk(clk), .rst(rst), .ce(ce), .pixValid(pixValid), .pixData(pixData),
      .vblankStart(vblankStart), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .histIrq(histIrq));

   fbh_pix_source src (.clk(clk), .pixValid(pixValid), .pixData(pixData), .vblankStart(vblankStart));

   task automatic endOfTest();
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      chkWord({31'h0, got}, {31'h0, exp});
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) errorCnt++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chkWord(rd, exp);
   endtask

   initial begin
      #200000;
      errorCnt++;
      endOfTest();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr(CTRL_OFFS, 32'h1);
      rdChk(CTRL_OFFS, 32'h0000_0001);
      src.sendFrame(rows[0].pix, 0, 1'b0);
      rdChk(CTRL_OFFS, 32'h0001_0001);
      for (int i = 0; i < 8; i++) begin
         ctl = {30'h0, rows[i].mode, 1'b1};
         wr(CTRL_OFFS, ctl);
         src.sendFrame(rows[i].pix, 0, 1'b0);
         wr(GUARD_OFFS, 32'hC040_0000);
         src.sendFrame(rows[i].pix, i + 3, i[0]);
         chkBit(histIrq, 1'b1);
         rdChk(GUARD_OFFS, 32'hC040_0000);
         apb(1'b0, BIN_OFFS, 32'h0);
         chkBit(rd[BIN_BUSY_BIT], 1'b1);
         wr(CTRL_OFFS, ctl);
         for (int k = 0; k < 32; k++) begin
            rdChk(BIN_OFFS, (k == rows[i].bin) ? i + 3 : 0);
         end
      end
      // Difference equal to the guardband must not count, one above must
      wr(GUARD_OFFS, 32'h8040_000A);
      src.sendFrame(rows[0].pix, 0, 1'b0);
      rdChk(GUARD_OFFS, 32'h0040_000A);
      wr(GUARD_OFFS, 32'h4040_0009);
      src.sendFrame(rows[0].pix, 0, 1'b0);
      rdChk(GUARD_OFFS, 32'hC040_0009);
      // Delay of three, broken once by a matching frame
      wr(GUARD_OFFS, 32'h80C0_0000);
      for (int j = 0; j < 5; j++) begin
         src.sendFrame(rows[0].pix, (j == 2) ? 0 : 4, 1'b0);
      end
      rdChk(GUARD_OFFS, 32'h00C0_0000);
      src.sendFrame(rows[0].pix, 4, 1'b0);
      rdChk(GUARD_OFFS, 32'h80C0_0000);
      chkBit(histIrq, 1'b0);
      // Pending status blocks further events and saved copies
      for (int j = 0; j < 3; j++) begin
         src.sendFrame(rows[0].pix, 0, 1'b0);
      end
      wr(GUARD_OFFS, 32'h00C0_0000);
      rdChk(GUARD_OFFS, 32'h80C0_0000);
      wr(GUARD_OFFS, 32'h80C0_0000);
      rdChk(GUARD_OFFS, 32'h00C0_0000);
      wr(CTRL_OFFS, 32'h0000_1F01);
      rdChk(BIN_OFFS, 32'h4);
      rdChk(BIN_OFFS, 32'h0);
      // Function switch takes effect at vblank, after which bin reads report busy
      wr(CTRL_OFFS, 32'h5);
      src.sendFrame(rows[0].pix, 0, 1'b0);
      apb(1'b0, BIN_OFFS, 32'h0);
      chkBit(rd[BIN_BUSY_BIT], 1'b1);
      wr(CTRL_OFFS, 32'h1);
      src.sendFrame(rows[0].pix, 0, 1'b0);
      rdChk(BIN_OFFS, 32'h0);
      rdChk(GUARD_OFFS, 32'h00C0_0000);
      apb(1'b0, 12'h00C, 32'h0);
      chkBit(err, 1'b1);
      chkWord(rd, 32'h0);
      // Clock enable low: a write in that window is ignored
      ce <= 1'b0;
      wr(GUARD_OFFS, 32'h0000_0005);
      ce <= 1'b1;
      rdChk(GUARD_OFFS, 32'h00C0_0000);
      // Second reset in mid-run clears every register, with status and a saved bin set first
      wr(GUARD_OFFS, 32'h4000_0000);
      src.sendFrame(rows[1].pix, 4, 1'b0);
      chkBit(histIrq, 1'b1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chkBit(histIrq, 1'b0);
      rdChk(CTRL_OFFS, 32'h0);
      rdChk(GUARD_OFFS, 32'h0);
      rdChk(BIN_OFFS, 32'h0);
      endOfTest();
   end
endmodule // tb
